// file: dss_seq.sv
// dss_seq.sv: sixteen-step, sixteen-output drum step sequencer, APB slave.
// assumes start, jog, reset and event lines arrive asynchronously,
// scan_tick is a one-cycle pulse on pclk, and pclk runs at 50 MHz.
//
// Functional notes
// (R1) sixteen steps, each with an on/off value for sixteen outputs
// (R2) all steps share the same sixteen outputs, each step its own pattern
// (R3) all variants advance on time; three also on events, timed has none
// (R4) pattern goes out as one word or as sixteen bits per variant
// (R5) timebase programmable 0.01 s to 99.99 s, common to all steps
// (R6) step time is 0.01 s times timebase times the step's counts
// (R7) timebase and per-step counts accept values up to 9999
// (R8) state is evaluated once per update tick only; jog, reset and run entry act on any pclk cycle
// (R9) on entering a step its pattern is driven at once
// (R10) event steps wait while event false, time runs only while true
// (R11) when a step's counts expire the sequencer moves to the next step
// (R12) each step advances on event, on time, or on both
// (R13) any step may be last; fewer outputs used via pattern and mask
// (R14) four status counters: elapsed, sub timer, preset step, current step
// (R15) sub timer reported in 0.01 s units toward one count
// (R16) preset step status changes only by reconfiguration
// (R17) while reset is active the sequencer sits at the preset step
// (R18) last step done sets completion flag and complete state; reset clears
// (R19) complete state holds the last step's masked pattern
// (R20) complete state ignores start and jog
// (R21) masked variants gate each output with an enable mask
// (R22) reset beats start; start runs; start off freezes and holds outputs
// (R23) jog rising edge advances one step regardless of start; timed has none
// (R24) mask bit 1 drives the output, 0 leaves it unchanged; mask per step
// (R25) run entry and reset go to preset step, drive it, clear the flag
// (R26) 0.01 s ticks fill sub timer; at timebase count up and clear it
// (R27) every step change, jog too, clears elapsed and sub timer
`timescale 1ns/100ps
`include "dss_defs.svh"

module dss_seq
    import dss_pkg::*;
#(
    parameter int REF_CYCLES = `DSS_REF_CYCLES
) (
    // clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        ce,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // control lines from surrounding logic
    input  wire logic        scan_tick,
    input  wire logic        start_in,
    input  wire logic        jog_in,
    input  wire logic        seq_reset_in,
    input  wire logic [15:0] step_event_input,
    // outputs
    output logic      [15:0] out_word,
    output logic      [15:0] out_bits,
    output logic             completion_flag
);

    if (REF_CYCLES < 2) begin : g_chk
        $error("dss_seq: REF_CYCLES must be at least 2");
    end

    localparam int RCW = $clog2(REF_CYCLES);

    // configuration registers
    dss_variant_e variant_r;
    logic         run_r;
    logic [13:0]  timebase_r;
    logic [4:0]   preset_r;
    logic [4:0]   last_r;
    logic [15:0]  pat_r  [16];
    logic [15:0]  mask_r [16];
    logic [15:0]  cfg_r  [16];

    // sequencer state
    dss_state_e   state_r,   state_nxt;
    logic [4:0]   cur_r,     cur_nxt;
    logic [15:0]  elapsed_r, elapsed_nxt;
    logic [15:0]  sub_r,     sub_nxt;
    logic [15:0]  pend_r,    pend_nxt;
    logic         done_nxt;
    logic         run_d_r;
    logic [RCW-1:0] ref_cnt_r;
    logic         ref_pulse_r;

    // input synchronisers: start, jog, reset, events
    logic [18:0]  s1_r, s2_r, s3_r, sv_r;
    logic         jog_d_r;

    // apb
    logic         pready_r, pslverr_r;
    logic [31:0]  prdata_r;

    assign prdata          = prdata_r;
    assign pready          = pready_r;
    assign pslverr         = pslverr_r;

    // address decode
    wire        setup_ph  = psel & ~penable;
    wire        wr_en     = psel & penable & pready_r & pwrite & ce;
    wire        in_low    = (paddr[11:6] == 6'h00);
    wire        in_pat    = (paddr[11:6] == 6'h01);
    wire        in_mask   = (paddr[11:6] == 6'h02);
    wire        in_cfg    = (paddr[11:6] == 6'h03);
    wire [3:0]  widx      = paddr[5:2];
    wire        low_hit   = in_low && (paddr[5:2] <= 4'h8);
    wire        addr_hit  = (low_hit | in_pat | in_mask | in_cfg)
                            && (paddr[1:0] == 2'h0);
    wire        wr_ctrl   = wr_en && (paddr == `DSS_OFF_CTRL);
    wire        wr_tb     = wr_en && (paddr == `DSS_OFF_TIMEBASE);
    wire        wr_pre    = wr_en && (paddr == `DSS_OFF_PRESET);
    wire        wr_last   = wr_en && (paddr == `DSS_OFF_LAST);

    // settings clamp into their legal ranges
    wire [13:0] tb_wr     = (pwdata[13:0] > `DSS_MAX_SETTING) ?
                            `DSS_MAX_SETTING : pwdata[13:0]; // [R5] [R7]
    wire [4:0]  step_wr   = (pwdata[4:0] == 5'h00) ? 5'h01 :
                            (pwdata[4:0] > `DSS_NUM_STEPS) ?
                            `DSS_NUM_STEPS : pwdata[4:0]; // [R13]

    // status view
    wire        in_run    = (state_r != DSS_ST_IDLE);
    wire [31:0] stat_word = {30'h0, in_run, completion_flag};

    wire [31:0] low_mux   =
        (paddr[5:2] == 4'h0) ? {29'h0, run_r, variant_r} :
        (paddr[5:2] == 4'h1) ? {18'h0, timebase_r} :
        (paddr[5:2] == 4'h2) ? {27'h0, preset_r} :
        (paddr[5:2] == 4'h3) ? {27'h0, last_r} :
        (paddr[5:2] == 4'h4) ? stat_word :
        (paddr[5:2] == 4'h5) ? {16'h0, elapsed_r} :              // [R14]
        (paddr[5:2] == 4'h6) ? {16'h0, sub_r} :                  // [R15]
        (paddr[5:2] == 4'h7) ? {27'h0, preset_r} :               // [R16]
                               {27'h0, cur_r};
    wire [31:0] rd_mux    =
        !addr_hit ? 32'h0 :
        in_low    ? low_mux :
        in_pat    ? {16'h0, pat_r[widx]} :
        in_mask   ? {16'h0, mask_r[widx]} :
                    {16'h0, cfg_r[widx]};

    // bus answers: zero wait states, one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r  <= 32'h0;
        end else if (ce) begin
            pready_r  <= setup_ph;
            pslverr_r <= setup_ph & ~addr_hit;
            if (setup_ph && !pwrite) begin
                prdata_r <= rd_mux;
            end
        end
    end

    // global settings
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            variant_r  <= DSS_VAR_TIMED;
            run_r      <= 1'b0;
            timebase_r <= `DSS_RST_TIMEBASE;
            preset_r   <= `DSS_RST_STEP;
            last_r     <= `DSS_RST_LAST;
        end else begin
            if (wr_ctrl) begin
                variant_r <= dss_variant_e'(pwdata[1:0]);
                run_r     <= pwdata[`DSS_CTRL_RUN_BIT];
            end
            if (wr_tb) begin
                timebase_r <= tb_wr;
            end
            if (wr_pre) begin
                preset_r <= step_wr; // [R16]
            end
            if (wr_last) begin
                last_r <= step_wr; // [R13]
            end
        end
    end

    // per-step pattern, mask and transition tables
    for (genvar g = 0; g < 16; g++) begin : g_step
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pat_r[g]  <= `DSS_RST_PATTERN;
                mask_r[g] <= `DSS_RST_MASK;
                cfg_r[g]  <= `DSS_RST_STEPCFG;
            end else if (wr_en && widx == 4'(g)) begin
                if (in_pat) begin
                    pat_r[g] <= pwdata[15:0]; // [R1] [R2]
                end
                if (in_mask) begin
                    mask_r[g] <= pwdata[15:0]; // [R24]
                end
                if (in_cfg) begin
                    cfg_r[g] <= {pwdata[15:14],
                                 (pwdata[13:0] > `DSS_MAX_SETTING) ?
                                 `DSS_MAX_SETTING : pwdata[13:0]}; // [R7]
                end
            end
        end
    end

    // three-stage sync; a change counts once stages two and three agree
    wire [18:0] raw_in = {seq_reset_in, jog_in, start_in, step_event_input};
    wire [18:0] sv_nxt = (s2_r & s3_r) | (sv_r & (s2_r ^ s3_r));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r    <= 19'h0;
            s2_r    <= 19'h0;
            s3_r    <= 19'h0;
            sv_r    <= 19'h0;
            jog_d_r <= 1'b0;
        end else if (ce) begin
            s1_r    <= raw_in;
            s2_r    <= s1_r;
            s3_r    <= s2_r;
            sv_r    <= sv_nxt;
            jog_d_r <= sv_r[17];
        end
    end

    wire        rst_v    = sv_r[18];
    wire        start_v  = sv_r[16];
    wire [15:0] event_v  = sv_r[15:0];
    wire        jog_rise = sv_r[17] & ~jog_d_r;

    // 0.01 s reference from pclk
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ref_cnt_r   <= '0;
            ref_pulse_r <= 1'b0;
        end else if (ce) begin
            ref_pulse_r <= (ref_cnt_r == RCW'(REF_CYCLES - 1));
            if (ref_cnt_r == RCW'(REF_CYCLES - 1)) begin
                ref_cnt_r <= '0;
            end else begin
                ref_cnt_r <= ref_cnt_r + RCW'(1);
            end
        end
    end

    // current step decode
    wire [3:0]  cur_idx   = 4'(cur_r - 5'h01);
    wire [15:0] cur_cfg   = cfg_r[cur_idx];
    wire [13:0] cur_cnts  = cur_cfg[`DSS_CFG_CNT_MSB:0];
    wire        has_evt   = (variant_r != DSS_VAR_TIMED)
                            && cur_cfg[`DSS_CFG_EVT_BIT]; // [R3] [R12]
    wire        use_time  = cur_cfg[`DSS_CFG_TIME_BIT] | ~has_evt; // [R12]
    wire        evt_ok    = !has_evt || event_v[cur_idx]; // [R10]
    wire        jog_ok    = (variant_r != DSS_VAR_TIMED) && jog_rise; // [R23]
    wire        is_last   = (cur_r == last_r) || (cur_r == `DSS_NUM_STEPS);
    wire        counting  = (state_r == DSS_ST_RUN) && start_v && !rst_v;
    wire [15:0] ref_add   = {15'h0, ref_pulse_r};
    wire [15:0] cs_now    = pend_r + ref_add;
    wire [15:0] sub_sum   = sub_r + cs_now; // [R26]
    wire [15:0] tb_eff    = (timebase_r == 14'h0) ? 16'h0001 :
                            {2'h0, timebase_r};
    wire [15:0] el_inc    = elapsed_r + 16'h0001;
    wire        count_up  = sub_sum >= tb_eff; // [R26]
    wire        cnt_exp   = count_up && (el_inc >= {2'h0, cur_cnts});
    wire        run_rise  = run_r & ~run_d_r;

    // step sequencing
    always_comb begin
        state_nxt   = state_r;
        cur_nxt     = cur_r;
        elapsed_nxt = elapsed_r;
        sub_nxt     = sub_r;
        done_nxt    = completion_flag;
        // ticks pile up between scans, discarded while frozen
        pend_nxt    = counting ? cs_now : 16'h0;
        if (!run_r) begin
            state_nxt = DSS_ST_IDLE;
        end else if (run_rise || rst_v) begin
            // reset beats start and jog, and holds the preset step
            state_nxt   = DSS_ST_RUN;                         // [R17] [R22]
            cur_nxt     = preset_r;                           // [R25]
            elapsed_nxt = 16'h0;
            sub_nxt     = 16'h0;
            done_nxt    = 1'b0;                               // [R18]
        end else if (state_r == DSS_ST_RUN) begin
            if (jog_ok) begin
                if (is_last) begin
                    state_nxt = DSS_ST_DONE;                  // [R18]
                    done_nxt  = 1'b1;
                end else begin
                    cur_nxt = cur_r + 5'h01;                  // [R23]
                end
                elapsed_nxt = 16'h0;                          // [R27]
                sub_nxt     = 16'h0;
                pend_nxt    = 16'h0;
            end else if (counting && scan_tick) begin         // [R8] [R22]
                pend_nxt = 16'h0;
                if (evt_ok) begin                             // [R10]
                    if (!use_time || cnt_exp) begin           // [R11] [R12]
                        if (is_last) begin
                            state_nxt = DSS_ST_DONE;          // [R18]
                            done_nxt  = 1'b1;
                        end else begin
                            cur_nxt = cur_r + 5'h01;
                        end
                        elapsed_nxt = 16'h0;                  // [R27]
                        sub_nxt     = 16'h0;
                    end else if (count_up) begin
                        elapsed_nxt = el_inc;                 // [R6] [R26]
                        sub_nxt     = 16'h0;
                    end else begin
                        sub_nxt = sub_sum;                    // [R15]
                    end
                end
            end
        end
        // complete state: start and jog change nothing
    end

    // outputs follow the step being entered in the same cycle
    wire [3:0]  nxt_idx   = 4'(cur_nxt - 5'h01);
    wire        masked    = (variant_r == DSS_VAR_MASK_BITS)
                            || (variant_r == DSS_VAR_MASK_WORD);
    wire [15:0] en_mask   = masked ? mask_r[nxt_idx] : 16'hffff; // [R21]
    wire        to_word   = (variant_r == DSS_VAR_MASK_WORD);      // [R4]
    wire        drive     = (state_nxt == DSS_ST_RUN);
    wire [15:0] word_nxt  = (pat_r[nxt_idx] & en_mask)
                            | (out_word & ~en_mask);              // [R24]
    wire [15:0] bits_nxt  = (pat_r[nxt_idx] & en_mask)
                            | (out_bits & ~en_mask);              // [R24]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r         <= DSS_ST_IDLE;
            cur_r           <= `DSS_RST_STEP;
            elapsed_r       <= 16'h0;
            sub_r           <= 16'h0;
            pend_r          <= 16'h0;
            completion_flag <= 1'b0;
            run_d_r         <= 1'b0;
        end else if (ce) begin
            state_r         <= state_nxt;
            cur_r           <= cur_nxt;
            elapsed_r       <= elapsed_nxt;
            sub_r           <= sub_nxt;
            pend_r          <= pend_nxt;
            completion_flag <= done_nxt;
            run_d_r         <= run_r;
        end
    end

    // done and frozen states keep the last driven pattern
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_word <= 16'h0;
            out_bits <= 16'h0;
        end else if (ce && drive) begin
            if (to_word) begin
                out_word <= word_nxt;                         // [R9] [R4]
            end else begin
                out_bits <= bits_nxt;                         // [R9] [R19]
            end
        end
    end

endmodule : dss_seq

// file: dss_defs.svh
// dss_defs.svh: offsets, field positions, reset values and timing counts
// of the drum step sequencer. definitions only; included by bare name.
`ifndef DSS_DEFS_SVH
`define DSS_DEFS_SVH

// control and status words, byte addresses
`define DSS_OFF_CTRL      12'h000
`define DSS_OFF_TIMEBASE  12'h004
`define DSS_OFF_PRESET    12'h008
`define DSS_OFF_LAST      12'h00c
`define DSS_OFF_STATUS    12'h010
`define DSS_OFF_ELAPSED   12'h014
`define DSS_OFF_SUBTMR    12'h018
`define DSS_OFF_PRESETNUM 12'h01c
`define DSS_OFF_CURSTEP   12'h020
// per-step tables, sixteen words each
`define DSS_OFF_PATTERN   12'h040
`define DSS_OFF_MASK      12'h080
`define DSS_OFF_STEPCFG   12'h0c0

// control word fields
`define DSS_CTRL_VAR_LSB  0
`define DSS_CTRL_RUN_BIT  2
// step config word fields
`define DSS_CFG_CNT_MSB   13
`define DSS_CFG_TIME_BIT  14
`define DSS_CFG_EVT_BIT   15
// status word fields
`define DSS_STAT_DONE_BIT 0
`define DSS_STAT_RUN_BIT  1

// reset values
`define DSS_RST_TIMEBASE  14'h0001
`define DSS_RST_STEP      5'h01
`define DSS_RST_LAST      5'h10
`define DSS_RST_STEPCFG   16'h4001
`define DSS_RST_PATTERN   16'h0000
`define DSS_RST_MASK      16'hffff

// limits
`define DSS_MAX_SETTING   14'h270f
`define DSS_NUM_STEPS     5'h10

// timing: 0.01 s reference against a 20 ns clock
`define DSS_REF_PERIOD_NS 10000000
`define DSS_CLK_PERIOD_NS 20
`define DSS_REF_CYCLES    (`DSS_REF_PERIOD_NS / `DSS_CLK_PERIOD_NS)

`endif

// file: dss_pkg.sv
// dss_pkg.sv: types of the drum step sequencer.
// assumes nothing of its surroundings.
package dss_pkg;

    typedef enum logic [1:0] {
        DSS_VAR_TIMED      = 2'h0,
        DSS_VAR_EVENT_BITS = 2'h1,
        DSS_VAR_MASK_BITS  = 2'h2,
        DSS_VAR_MASK_WORD  = 2'h3
    } dss_variant_e;

    typedef enum logic [2:0] {
        DSS_ST_IDLE = 3'b001,
        DSS_ST_RUN  = 3'b010,
        DSS_ST_DONE = 3'b100
    } dss_state_e;

endpackage : dss_pkg

// file: dss_seq_checker.sv
// dss_seq_checker.sv: port assertions of the drum step sequencer.
// assumes ce stays high and jog pulses stay high for eight cycles.
`timescale 1ns/100ps
module dss_seq_checker (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        ce,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // control lines and outputs
    input wire logic        scan_tick,
    input wire logic        jog_in,
    input wire logic        seq_reset_in,
    input wire logic [15:0] out_word,
    input wire logic [15:0] out_bits,
    input wire logic        completion_flag
);
    logic [2:0] wr_hist_r;
    // run entry moves outputs a cycle or two after the write lands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_hist_r <= 3'h0;
        end else begin
            wr_hist_r <= {wr_hist_r[1:0], psel & penable & pwrite & pready};
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_APB_ANSWER:
        assert property (psel && !penable && ce |=> pready)
        else $error("setup not answered in the next cycle");
    AST_READY_PULSE:
        assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    AST_ERR_WITH_READY:
        assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    AST_ERR_READ_ZERO:
        assert property (pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned nonzero data");
    AST_FLAG_CLEAR_CAUSE:
        assert property ($fell(completion_flag) |-> seq_reset_in
                         || |wr_hist_r)
        else $error("completion flag dropped without reset");
    AST_FLAG_SET_CAUSE:
        assert property ($rose(completion_flag) |-> $past(scan_tick)
                         || $past(scan_tick, 2) || jog_in)
        else $error("completion flag rose without tick or jog");
    AST_DONE_HOLDS:
        assert property (completion_flag && $past(completion_flag)
                         |-> $stable(out_bits) && $stable(out_word))
        else $error("outputs moved in the complete state");
    AST_OUT_CAUSE:
        assert property ($changed(out_bits) || $changed(out_word)
                         |-> $past(scan_tick) || $past(scan_tick, 2)
                         || jog_in || seq_reset_in || |wr_hist_r)
        else $error("outputs changed without tick, jog or reset");
    COV_DONE: cover property ($rose(completion_flag));
    COV_REFUSED: cover property (pslverr);
    COV_JOG_STEP: cover property (jog_in && $changed(out_word));
endmodule : dss_seq_checker

bind dss_seq dss_seq_checker i_chk (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scan_tick(scan_tick),
    .jog_in(jog_in), .seq_reset_in(seq_reset_in), .out_word(out_word),
    .out_bits(out_bits), .completion_flag(completion_flag));

// file: dss_ctl_model.sv
// dss_ctl_model.sv: control logic around the sequencer, driving its pins.
// assumes level commands and one-cycle jog requests from the bench.
`timescale 1ns/100ps
module dss_ctl_model #(
    parameter int SCAN = 3
) (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // commands from the bench
    input  wire logic        start_cmd,
    input  wire logic        reset_cmd,
    input  wire logic        jog_cmd,
    input  wire logic [15:0] event_cmd,
    // sequencer pins
    output logic             scan_tick,
    output logic             start_in,
    output logic             jog_in,
    output logic             seq_reset_in,
    output logic [15:0]      step_event_input
);
    logic [7:0] scan_cnt_r;
    logic [4:0] jog_cnt_r;
    // eight cycles high, at least nine low: well past the pin sync window
    assign jog_in = jog_cnt_r > 5'h08;
    assign scan_tick = scan_cnt_r == 8'h00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scan_cnt_r <= 8'h00;
            jog_cnt_r <= 5'h00;
            start_in <= 1'b0;
            seq_reset_in <= 1'b0;
            step_event_input <= 16'h0000;
        end else begin
            scan_cnt_r <= scan_tick ? 8'(SCAN - 1) : scan_cnt_r - 8'h01;
            start_in <= start_cmd;
            seq_reset_in <= reset_cmd;
            step_event_input <= event_cmd;
            if (jog_cmd && jog_cnt_r == 5'h00) begin
                jog_cnt_r <= 5'h10;
            end else if (jog_cnt_r != 5'h00) begin
                jog_cnt_r <= jog_cnt_r - 5'h01;
            end
        end
    end
endmodule : dss_ctl_model

// file: test_drum_step_sequencer.sv
// test_drum_step_sequencer.sv: self-checking bench of the drum sequencer.
// assumes the sequencer, its bound checker and the control model.
`timescale 1ns/100ps
`include "dss_defs.svh"
module test_drum_step_sequencer;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic        pwrite = 1'b0, start_cmd = 1'b0, reset_cmd = 1'b0;
    logic        jog_cmd = 1'b0, pready, pslverr, completion_flag;
    logic        scan_tick, start_in, jog_in, seq_reset_in;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [15:0] event_cmd = 16'h0, step_event_input, out_word, out_bits;
    int          n_errors = 0, samples_checked = 0, waited;
    always #10 pclk = ~pclk;
    dss_seq #(.REF_CYCLES(4)) i_dut (
        .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scan_tick(scan_tick), .start_in(start_in), .jog_in(jog_in),
        .seq_reset_in(seq_reset_in), .step_event_input(step_event_input),
        .out_word(out_word), .out_bits(out_bits),
        .completion_flag(completion_flag));
    dss_ctl_model #(.SCAN(3)) i_ctl (
        .pclk(pclk), .presetn(presetn), .start_cmd(start_cmd),
        .reset_cmd(reset_cmd), .jog_cmd(jog_cmd), .event_cmd(event_cmd),
        .scan_tick(scan_tick), .start_in(start_in), .jog_in(jog_in),
        .seq_reset_in(seq_reset_in), .step_event_input(step_event_input));
    task automatic report_and_stop;
        $display("errors %0d, checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    // one transfer; waits for pready, then one idle cycle
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] q,
                       output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            n_errors++;
            report_and_stop();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask : wr
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(q, exp);
    endtask : rdc
    // which: 0 bit outputs, 1 word output, 2 completion flag
    task automatic ws(input int which, input logic [15:0] exp);
        logic [15:0] v;
        int          n;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
            v = which == 0 ? out_bits : which == 1 ? out_word
                : {15'h0, completion_flag};
        end while (v !== exp && n < 400);
        waited = n;
        chk({16'h0, v}, {16'h0, exp});
        if (v !== exp) report_and_stop();
    endtask : ws
    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask : idle
    task automatic jog;
        jog_cmd <= 1'b1;
        @(posedge pclk);
        jog_cmd <= 1'b0;
        idle(20);
    endtask : jog
    task automatic run_entry(input logic [1:0] variant);
        wr(`DSS_OFF_CTRL, 32'h0);
        wr(`DSS_OFF_CTRL, {29'h0, 1'b1, variant});
    endtask : run_entry
    task automatic t_regs;
        logic [31:0] q;
        logic        e;
        rdc(`DSS_OFF_ELAPSED, 32'h0);
        rdc(`DSS_OFF_SUBTMR, 32'h0);
        rdc(`DSS_OFF_PRESETNUM, 32'h1);
        wr(`DSS_OFF_CURSTEP, 32'h5);
        rdc(`DSS_OFF_CURSTEP, 32'h1);
        apb(1'b0, 12'h03c, 32'h0, q, e);
        chk({31'h0, e}, 32'h1);
        chk(q, 32'h0);
    endtask : t_regs
    task automatic t_timed;
        wr(`DSS_OFF_TIMEBASE, 32'h2);
        wr(`DSS_OFF_LAST, 32'h2);
        wr(`DSS_OFF_PATTERN, 32'h00a5);
        wr(`DSS_OFF_PATTERN + 12'h004, 32'h5a00);
        wr(`DSS_OFF_STEPCFG, 32'h4003);
        wr(`DSS_OFF_STEPCFG + 12'h004, 32'h4002);
        run_entry(2'h0);
        ws(0, 16'h00a5);
        jog();
        chk({16'h0, out_bits}, 32'h00a5);
        start_cmd <= 1'b1;
        ws(0, 16'h5a00);
        chk({31'h0, waited >= 20 && waited <= 45}, 32'h1);
        ws(2, 16'h1);
        chk({16'h0, out_bits}, 32'h5a00);
        reset_cmd <= 1'b1;
        idle(40);
        chk({31'h0, completion_flag}, 32'h0);
        chk({16'h0, out_bits}, 32'h00a5);
        rdc(`DSS_OFF_CURSTEP, 32'h1);
        reset_cmd <= 1'b0;
        start_cmd <= 1'b0;
    endtask : t_timed
    task automatic t_event;
        wr(`DSS_OFF_STEPCFG, 32'h8000);
        wr(`DSS_OFF_STEPCFG + 12'h004, 32'hc001);
        run_entry(2'h1);
        start_cmd <= 1'b1;
        idle(40);
        chk({16'h0, out_bits}, 32'h00a5);
        event_cmd <= 16'h0001;
        ws(0, 16'h5a00);
        idle(40);
        rdc(`DSS_OFF_SUBTMR, 32'h0);
        event_cmd <= 16'h0003;
        ws(2, 16'h1);
        jog();
        rdc(`DSS_OFF_CURSTEP, 32'h2);
        chk({16'h0, out_bits}, 32'h5a00);
        start_cmd <= 1'b0;
    endtask : t_event
    task automatic t_mask_jog;
        wr(`DSS_OFF_PATTERN, 32'hffff);
        wr(`DSS_OFF_MASK + 12'h004, 32'h00ff);
        wr(`DSS_OFF_STEPCFG, 32'h4063);
        wr(`DSS_OFF_STEPCFG + 12'h004, 32'h4001);
        run_entry(2'h3);
        ws(1, 16'hffff);
        start_cmd <= 1'b1;
        idle(30);
        start_cmd <= 1'b0;
        jog();
        ws(1, 16'hff00);
        rdc(`DSS_OFF_CURSTEP, 32'h2);
        rdc(`DSS_OFF_ELAPSED, 32'h0);
        idle(60);
        chk({16'h0, out_word}, 32'hff00);
        chk({31'h0, completion_flag}, 32'h0);
        start_cmd <= 1'b1;
        ws(2, 16'h1);
        start_cmd <= 1'b0;
        run_entry(2'h2);
        ws(0, 16'hffff);
    endtask : t_mask_jog
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_timed();
        t_event();
        t_mask_jog();
        report_and_stop();
    end
endmodule : test_drum_step_sequencer
